//--- design/efr_regs.sv
// Embedded function register page behind an AHB-Lite slave port.
// Assumes event flags, step pulses and status levels arrive on hclk.
`timescale 1ns/1ps
module efr_regs
    import efr_pkg::*;
#(
    parameter int unsigned DIV_12P5_CYC = DIV_12P5,
    parameter int unsigned DIV_26_CYC = DIV_26,
    parameter int unsigned DIV_52_CYC = DIV_52,
    parameter int unsigned DIV_104_CYC = DIV_104
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // State machine engine event flags.
    input wire logic [7:0] sm_event_flags [NUM_SM],
    // Pedometer algorithm status.
    input wire logic step_pulse,
    input wire logic pedometer_window_flag,
    input wire logic pedometer_count_bit_flag,
    // Processing ticks and init requests.
    output logic engine_tick,
    output logic learning_tick,
    output logic motion_algo_init,
    output logic tilt_algo_init,
    output logic pedometer_algo_init,
    // Interrupt.
    output logic irq
);

    // ------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------
    efr_phase_t phase_reg;
    logic [7:0] idx_reg;
    logic mapped_reg;
    logic take;
    logic [31:0] hrdata_reg;
    logic [7:0] rd_val;
    logic wr_en;
    logic rd_en;
    logic [7:0] wbyte;

    // Only full-word transfers are expected, so hsize is not decoded.
    assign take = hsel && htrans[1] && hready;
    assign wr_en = (phase_reg == EFR_PH_WRITE) && mapped_reg;
    assign rd_en = (phase_reg == EFR_PH_READ) && mapped_reg;
    assign wbyte = hwdata[7:0];

    // Track the data phase; reads add one wait state so written values show.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= EFR_PH_IDLE;
        end else begin
            case (phase_reg)
                EFR_PH_READ: phase_reg <= EFR_PH_IDLE;
                default: begin
                    if (take && hwrite) begin
                        phase_reg <= EFR_PH_WRITE;
                    end else if (take) begin
                        phase_reg <= EFR_PH_READ;
                    end else begin
                        phase_reg <= EFR_PH_IDLE;
                    end
                end
            endcase
        end
    end

    // Capture the register index of an accepted address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_reg <= 8'h00;
            mapped_reg <= 1'b0;
        end else if (take) begin
            idx_reg <= haddr[9:2];
            mapped_reg <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
        end
    end

    assign hreadyout = (phase_reg != EFR_PH_READ);
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    // ------------------------------------------------------------------
    // Event flag registers
    // ------------------------------------------------------------------
    logic [7:0] sm_q_reg [NUM_SM];
    logic [NUM_SM-1:0] sm_any_reg;
    logic [NUM_SM-1:0] sm_rise;

    // Hold each engine's flags and note when its flags go from all clear to any set.
    for (genvar g = 0; g < NUM_SM; g++) begin : g_sm
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                sm_q_reg[g] <= 8'h00;
                sm_any_reg[g] <= 1'b0;
            end else begin
                sm_q_reg[g] <= sm_event_flags[g];
                sm_any_reg[g] <= |sm_q_reg[g];
            end
        end
        assign sm_rise[g] = (|sm_q_reg[g]) && !sm_any_reg[g];
    end

    // ------------------------------------------------------------------
    // Rate configuration
    // ------------------------------------------------------------------
    logic [1:0] eng_rate_reg;
    logic [1:0] lrn_rate_reg;

    // Only the two-bit fields are stored; fixed bits read back as documented.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eng_rate_reg <= RATE_RST;
            lrn_rate_reg <= RATE_RST;
        end else if (wr_en && idx_reg == IDX_ENG_RATE) begin
            eng_rate_reg <= wbyte[ENG_RATE_LSB +: 2];
        end else if (wr_en && idx_reg == IDX_LRN_RATE) begin
            lrn_rate_reg <= wbyte[LRN_RATE_LSB +: 2];
        end
    end

    // Processing tick for the state machine engine.
    efr_rate_tick #(
        .DIV_0(DIV_12P5_CYC),
        .DIV_1(DIV_26_CYC),
        .DIV_2(DIV_52_CYC),
        .DIV_3(DIV_104_CYC)
    ) u_engine_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .rate_sel(eng_rate_reg),
        .tick(engine_tick)
    );

    // Processing tick for the learning core.
    efr_rate_tick #(
        .DIV_0(DIV_12P5_CYC),
        .DIV_1(DIV_26_CYC),
        .DIV_2(DIV_52_CYC),
        .DIV_3(DIV_104_CYC)
    ) u_learning_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .rate_sel(lrn_rate_reg),
        .tick(learning_tick)
    );

    // ------------------------------------------------------------------
    // Pedometer source and count
    // ------------------------------------------------------------------
    efr_ped_if ped ();
    logic clr_req_reg;
    logic det_reg;
    logic win_reg;
    logic cbit_reg;
    logic ovf_q_reg;
    logic src_read;

    assign src_read = rd_en && idx_reg == IDX_PED_SRC;
    assign ped.step_pulse = step_pulse;
    assign ped.clear = clr_req_reg;

    efr_step_count u_step_count (
        .hclk(hclk),
        .hresetn(hresetn),
        .ped(ped)
    );

    // The clear request stays set until software writes it back to zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clr_req_reg <= 1'b0;
        end else if (wr_en && idx_reg == IDX_PED_SRC) begin
            clr_req_reg <= wbyte[SRC_CLR_BIT];
        end
    end

    // Detect flag is sticky until the source register is read; a step wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            det_reg <= 1'b0;
        end else if (step_pulse) begin
            det_reg <= 1'b1;
        end else if (src_read) begin
            det_reg <= 1'b0;
        end
    end

    // Status levels from the pedometer algorithm, and the count keeper's overflow flag.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_reg <= 1'b0;
            cbit_reg <= 1'b0;
            ovf_q_reg <= 1'b0;
        end else begin
            win_reg <= pedometer_window_flag;
            cbit_reg <= pedometer_count_bit_flag;
            ovf_q_reg <= ped.overflow;
        end
    end

    // ------------------------------------------------------------------
    // Algorithm init requests
    // ------------------------------------------------------------------
    logic [2:0] init_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_reg <= 3'h0;
        end else if (wr_en && idx_reg == IDX_INIT) begin
            init_reg <= wbyte[INIT_PED_BIT +: 3];
        end
    end

    assign pedometer_algo_init = init_reg[INIT_PED_BIT - INIT_PED_BIT];
    assign tilt_algo_init = init_reg[INIT_TILT_BIT - INIT_PED_BIT];
    assign motion_algo_init = init_reg[INIT_MOT_BIT - INIT_PED_BIT];

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_ev;

    assign irq_ev = {sm_rise, ped.overflow && !ovf_q_reg, step_pulse};

    // Read clears the status; an event in the same cycle survives.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= '0;
        end else if (rd_en && idx_reg == IDX_IRQ_STAT) begin
            irq_stat_reg <= irq_ev;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_ev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_reg <= IRQ_MASK_RST;
        end else if (wr_en && idx_reg == IDX_IRQ_MASK) begin
            irq_mask_reg <= wbyte[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Unmapped or unknown indices read as zero.
    always_comb begin
        rd_val = 8'h00;
        if (!mapped_reg) begin
            rd_val = 8'h00;
        end else if (idx_reg == IDX_SM14) begin
            rd_val = sm_q_reg[0];
        end else if (idx_reg == IDX_SM15) begin
            rd_val = sm_q_reg[1];
        end else if (idx_reg == IDX_SM16) begin
            rd_val = sm_q_reg[2];
        end else if (idx_reg == IDX_ENG_RATE) begin
            rd_val = ENG_FIXED_ONES | {3'h0, eng_rate_reg, 3'h0};
        end else if (idx_reg == IDX_LRN_RATE) begin
            rd_val = LRN_FIXED_ONES | {2'h0, lrn_rate_reg, 4'h0};
        end else if (idx_reg == IDX_CNT_LO) begin
            rd_val = ped.count[7:0];
        end else if (idx_reg == IDX_CNT_HI) begin
            rd_val = ped.count[15:8];
        end else if (idx_reg == IDX_PED_SRC) begin
            rd_val[SRC_CLR_BIT] = clr_req_reg;
            rd_val[SRC_DET_BIT] = det_reg;
            rd_val[SRC_WIN_BIT] = win_reg;
            rd_val[SRC_OVF_BIT] = ped.overflow;
            rd_val[SRC_CBIT_BIT] = cbit_reg;
        end else if (idx_reg == IDX_INIT) begin
            rd_val = {2'h0, init_reg, 3'h0};
        end else if (idx_reg == IDX_IRQ_STAT) begin
            rd_val = {3'h0, irq_stat_reg};
        end else if (idx_reg == IDX_IRQ_MASK) begin
            rd_val = {3'h0, irq_mask_reg};
        end
    end

    // Load read data during the wait cycle of a read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h00000000;
        end else if (phase_reg == EFR_PH_READ) begin
            hrdata_reg <= {24'h000000, rd_val};
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_read_of(logic [7:0] idx);
        (phase_reg == EFR_PH_READ) && mapped_reg && idx_reg == idx;
    endsequence

    sequence s_write_of(logic [7:0] idx);
        (phase_reg == EFR_PH_WRITE) && mapped_reg && idx_reg == idx;
    endsequence

    chk_sm_readback: assert property (@(posedge hclk) disable iff (!hresetn)
        s_read_of(IDX_SM15) |=> hreadyout && hrdata == {24'h000000, $past(sm_q_reg[1])})
        else $error("event register read back wrong flags");
    chk_engine_rate: assert property (@(posedge hclk) disable iff (!hresetn)
        s_write_of(IDX_ENG_RATE) ##2 s_read_of(IDX_ENG_RATE)
        |=> hrdata[ENG_RATE_LSB +: 2] == $past(hwdata[ENG_RATE_LSB +: 2], 3))
        else $error("engine rate field not stored");
    chk_learn_rate: assert property (@(posedge hclk) disable iff (!hresetn)
        s_write_of(IDX_LRN_RATE) |=> lrn_rate_reg == $past(hwdata[LRN_RATE_LSB +: 2]))
        else $error("learning rate field not stored");
    chk_count_high: assert property (@(posedge hclk) disable iff (!hresetn)
        s_read_of(IDX_CNT_HI) |=> hrdata[7:0] == $past(ped.count[15:8]))
        else $error("count high byte read wrong");
    chk_window_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        s_read_of(IDX_PED_SRC) |=> hrdata[SRC_WIN_BIT] == $past(win_reg))
        else $error("window flag read wrong");
    chk_detect_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        step_pulse |=> det_reg ##1 (det_reg || $past(src_read)))
        else $error("detect flag not held after a step");
    chk_clear_count: assert property (@(posedge hclk) disable iff (!hresetn)
        clr_req_reg ##1 clr_req_reg |-> ped.count == 16'h0000 && !ped.overflow)
        else $error("count not held clear during reset request");
    chk_init_bits: assert property (@(posedge hclk) disable iff (!hresetn)
        s_write_of(IDX_INIT) |=> motion_algo_init == $past(hwdata[INIT_MOT_BIT])
        && pedometer_algo_init == $past(hwdata[INIT_PED_BIT]))
        else $error("init request bits not stored");
    chk_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state length wrong");

endmodule // efr_regs

//--- design/efr_pkg.sv
// Shared constants and types for the embedded function register page.
// Assumes a single 40 MHz bus clock and word-aligned register slots.
package efr_pkg;

    // ------------------------------------------------------------------
    // Clock and processing rates
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    // Processing rates in tenths of a hertz, as printed: 12.5, 26, 52, 104 Hz.
    localparam int unsigned RATE_12P5_DHZ = 125;
    localparam int unsigned RATE_26_DHZ = 260;
    localparam int unsigned RATE_52_DHZ = 520;
    localparam int unsigned RATE_104_DHZ = 1040;
    // Clock cycles per processing tick, rounded down.
    localparam int unsigned DIV_12P5 = (CLK_HZ * 10) / RATE_12P5_DHZ;
    localparam int unsigned DIV_26 = (CLK_HZ * 10) / RATE_26_DHZ;
    localparam int unsigned DIV_52 = (CLK_HZ * 10) / RATE_52_DHZ;
    localparam int unsigned DIV_104 = (CLK_HZ * 10) / RATE_104_DHZ;
    localparam int unsigned TICK_CW = 22;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_SM14 = 8'h59;
    localparam logic [7:0] IDX_SM15 = 8'h5a;
    localparam logic [7:0] IDX_SM16 = 8'h5b;
    localparam logic [7:0] IDX_ENG_RATE = 8'h5f;
    localparam logic [7:0] IDX_LRN_RATE = 8'h60;
    localparam logic [7:0] IDX_CNT_LO = 8'h62;
    localparam logic [7:0] IDX_CNT_HI = 8'h63;
    localparam logic [7:0] IDX_PED_SRC = 8'h64;
    localparam logic [7:0] IDX_INIT = 8'h66;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h68;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h69;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int ENG_RATE_LSB = 3;
    localparam int LRN_RATE_LSB = 4;
    localparam logic [7:0] ENG_FIXED_ONES = 8'h43;
    localparam logic [7:0] LRN_FIXED_ONES = 8'h05;
    localparam logic [1:0] RATE_RST = 2'h1;
    localparam int SRC_CLR_BIT = 7;
    localparam int SRC_DET_BIT = 5;
    localparam int SRC_WIN_BIT = 4;
    localparam int SRC_OVF_BIT = 3;
    localparam int SRC_CBIT_BIT = 2;
    localparam int INIT_MOT_BIT = 5;
    localparam int INIT_TILT_BIT = 4;
    localparam int INIT_PED_BIT = 3;
    localparam int IRQ_W = 5;
    localparam int IRQ_DET = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_SM0 = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
    localparam int NUM_SM = 3;

    // Bus data phase tracking.
    typedef enum logic [2:0] {
        EFR_PH_IDLE = 3'b001,
        EFR_PH_WRITE = 3'b010,
        EFR_PH_READ = 3'b100
    } efr_phase_t;

endpackage

//--- design/efr_ped_if.sv
// Carrier between the register page and the pedometer count keeper.
// Assumes both ends run on the bus clock.
`timescale 1ns/1ps
interface efr_ped_if;
    logic step_pulse;
    logic clear;
    logic [15:0] count;
    logic overflow;
    modport counter (input step_pulse, input clear, output count, output overflow);
    modport ctrl (output step_pulse, output clear, input count, input overflow);
endinterface

//--- design/efr_step_count.sv
// Sixteen-bit pedometer count with overflow flag.
// Assumes step pulses and the clear level come from the bus clock domain.
`timescale 1ns/1ps
module efr_step_count
    import efr_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Link to the register page.
    efr_ped_if.counter ped
);
    logic [15:0] count_reg;
    logic overflow_reg;

    // Count steps; the clear holds count and overflow at zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= 16'h0000;
            overflow_reg <= 1'b0;
        end else if (ped.clear) begin
            count_reg <= 16'h0000;
            overflow_reg <= 1'b0;
        end else if (ped.step_pulse) begin
            count_reg <= count_reg + 16'h0001;
            if (count_reg == 16'hffff) begin
                overflow_reg <= 1'b1;
            end
        end
    end

    assign ped.count = count_reg;
    assign ped.overflow = overflow_reg;

    chk_count_advance: assert property (@(posedge hclk) disable iff (!hresetn)
        (ped.step_pulse && !ped.clear) |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("pedometer count did not advance by one");
    chk_overflow_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        (ped.step_pulse && !ped.clear && count_reg == 16'hffff) |=> overflow_reg)
        else $error("overflow flag not set on reaching the limit");

endmodule // efr_step_count

//--- design/efr_rate_tick.sv
// Processing tick generator for one selectable rate.
// Assumes the rate code is a register on the same clock.
`timescale 1ns/1ps
module efr_rate_tick
    import efr_pkg::*;
#(
    parameter int unsigned DIV_0 = DIV_12P5,
    parameter int unsigned DIV_1 = DIV_26,
    parameter int unsigned DIV_2 = DIV_52,
    parameter int unsigned DIV_3 = DIV_104
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Rate code and tick out.
    input wire logic [1:0] rate_sel,
    output logic tick
);
    logic [TICK_CW-1:0] cnt_reg;
    logic [TICK_CW-1:0] lim;
    logic [1:0] rate_q_reg;
    logic tick_reg;

    // Period in cycles for the current code.
    always_comb begin
        case (rate_sel)
            2'h0: lim = TICK_CW'(DIV_0);
            2'h1: lim = TICK_CW'(DIV_1);
            2'h2: lim = TICK_CW'(DIV_2);
            default: lim = TICK_CW'(DIV_3);
        endcase
    end

    // Restart the period whenever the rate code changes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= '0;
            rate_q_reg <= RATE_RST;
            tick_reg <= 1'b0;
        end else if (rate_sel != rate_q_reg) begin
            cnt_reg <= '0;
            rate_q_reg <= rate_sel;
            tick_reg <= 1'b0;
        end else if (cnt_reg == lim - TICK_CW'(1)) begin
            cnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + TICK_CW'(1);
            tick_reg <= 1'b0;
        end
    end

    assign tick = tick_reg;

    chk_tick_period: assert property (@(posedge hclk) disable iff (!hresetn)
        tick_reg |-> $past(cnt_reg) == $past(lim) - TICK_CW'(1))
        else $error("tick issued off the selected period");

endmodule // efr_rate_tick

//--- test/efr_host.sv
// Host bus master model that drives single word transfers on AHB-Lite.
// Assumes one slave, whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module efr_host (
    // Clock and bus answer.
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Bus request.
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // The bus is idle until the first transfer.
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
    end

    // One transfer, entered just after a rising edge; read data is taken at the last edge.
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                        output logic [7:0] rd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd}; // Only the low byte carries data.
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata[7:0];
    endtask
endmodule // efr_host

//--- test/test_efr_regs.sv
// Self-checking bench for the register page, run through the host model.
// Assumes short tick dividers of 8, 6, 4 and 3 cycles.
`timescale 1ns/1ps
module test_efr_regs import efr_pkg::*;;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, engine_tick, learning_tick, irq;
    logic motion_algo_init, tilt_algo_init, pedometer_algo_init;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] sm_event_flags [NUM_SM] = '{8'h00, 8'h00, 8'h00};
    logic step_pulse = 1'b0;
    logic pedometer_window_flag = 1'b0;
    logic pedometer_count_bit_flag = 1'b0;
    int fail_count = 0;
    int n_compared = 0;
    int n;
    logic [7:0] rd;
    int dv [4] = '{8, 6, 4, 3};

    // The 40 MHz bus clock.
    always #12.5 hclk = ~hclk;

    efr_regs #(.DIV_12P5_CYC(8), .DIV_26_CYC(6), .DIV_52_CYC(4), .DIV_104_CYC(3)) u_efr_regs (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sm_event_flags(sm_event_flags),
        .step_pulse(step_pulse), .pedometer_window_flag(pedometer_window_flag),
        .pedometer_count_bit_flag(pedometer_count_bit_flag), .engine_tick(engine_tick),
        .learning_tick(learning_tick), .motion_algo_init(motion_algo_init),
        .tilt_algo_init(tilt_algo_init), .pedometer_algo_init(pedometer_algo_init), .irq(irq));
    efr_host u_efr_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // Verdict and end of run.
    task automatic conclude();
        if (fail_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Value comparison.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register access and waiting helpers.
    task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
        u_efr_host.xfer(idx, 1'b0, 8'h00, rd);
        check({24'h0, rd}, {24'h0, exp});
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        u_efr_host.xfer(idx, 1'b1, d, rd);
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge hclk);
    endtask
    task automatic pulse(input int k);
        step_pulse <= 1'b1;
        idle(k);
        step_pulse <= 1'b0;
        idle(2);
    endtask
    // Cycles between two consecutive ticks of one generator.
    task automatic period(input logic lrn, output int cnt);
        cnt = 0;
        do @(posedge hclk); while ((lrn ? learning_tick : engine_tick) !== 1'b1);
        do begin
            @(posedge hclk);
            cnt++;
        end while ((lrn ? learning_tick : engine_tick) !== 1'b1);
    endtask

    // Watchdog against a hung handshake.
    initial begin
        idle(80000);
        fail_count++;
        conclude();
    end

    // Main sequence.
    initial begin
        idle(5);
        hresetn <= 1'b1;
        @(posedge hclk);
        rreg(IDX_ENG_RATE, 8'h4b);
        rreg(IDX_LRN_RATE, 8'h15);
        rreg(IDX_INIT, 8'h00);
        rreg(IDX_IRQ_MASK, 8'h00);
        sm_event_flags <= '{8'ha5, 8'h3c, 8'h81};
        idle(3);
        rreg(IDX_SM14, 8'ha5);
        rreg(IDX_SM15, 8'h3c);
        rreg(IDX_SM16, 8'h81);
        check({31'h0, irq}, 32'h0);
        wreg(IDX_IRQ_MASK, 8'h1c);
        idle(1);
        check({31'h0, irq}, 32'h1);
        rreg(IDX_IRQ_STAT, 8'h1c);
        idle(1);
        check({31'h0, irq}, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wreg(IDX_ENG_RATE, ENG_FIXED_ONES | 8'(c << ENG_RATE_LSB));
            rreg(IDX_ENG_RATE, ENG_FIXED_ONES | 8'(c << ENG_RATE_LSB));
            period(1'b0, n);
            check(n, dv[c]);
            wreg(IDX_LRN_RATE, LRN_FIXED_ONES | 8'(c << LRN_RATE_LSB));
            rreg(IDX_LRN_RATE, LRN_FIXED_ONES | 8'(c << LRN_RATE_LSB));
            period(1'b1, n);
            check(n, dv[c]);
        end
        pedometer_window_flag <= 1'b1;
        pedometer_count_bit_flag <= 1'b1;
        pulse(3);
        rreg(IDX_CNT_LO, 8'h03);
        rreg(IDX_CNT_HI, 8'h00);
        rreg(IDX_PED_SRC, 8'h34);
        rreg(IDX_PED_SRC, 8'h14);
        pedometer_window_flag <= 1'b0;
        pedometer_count_bit_flag <= 1'b0;
        pulse(65533);
        rreg(IDX_CNT_LO, 8'h00);
        rreg(IDX_CNT_HI, 8'h00);
        rreg(IDX_PED_SRC, 8'h28);
        rreg(IDX_IRQ_STAT, 8'h03);
        wreg(IDX_PED_SRC, 8'h80);
        pulse(2);
        rreg(IDX_CNT_LO, 8'h00);
        wreg(IDX_PED_SRC, 8'h00);
        pulse(1);
        rreg(IDX_CNT_LO, 8'h01);
        rreg(IDX_PED_SRC, 8'h20);
        wreg(IDX_INIT, 8'h38);
        rreg(IDX_INIT, 8'h38);
        check({29'h0, motion_algo_init, tilt_algo_init, pedometer_algo_init}, 32'h7);
        wreg(IDX_INIT, 8'h10);
        idle(1);
        check({29'h0, motion_algo_init, tilt_algo_init, pedometer_algo_init}, 32'h2);
        wreg(8'h70, 8'hff);
        rreg(8'h70, 8'h00);
        check({31'h0, hresp}, 32'h0);
        conclude();
    end
endmodule // test_efr_regs
